// ---- verilog/large_dual_port_block_ram.sv ----
// Large synchronous two-port RAM with byte masking and mixed widths.
// Assumes all inputs synchronous to clk_in; configuration held static.
`timescale 1ns/1ps
`default_nettype none
`include "mram_defs.svh"

module large_dual_port_block_ram (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // Configuration
   input wire mram_pkg::mode_e mode_in,
   input wire mram_pkg::width_e width_a_in,
   input wire mram_pkg::width_e width_b_in,
   input wire logic narrow_a_in,
   input wire logic narrow_b_in,
   input wire logic outreg_a_in,
   input wire logic outreg_b_in,
   // Port A
   input wire logic ce_a_in,
   input wire logic clr_a_in,
   input wire logic we_a_in,
   input wire logic [`MRAM_AW-1:0] addr_a_in,
   input wire logic [`MRAM_PORT_DW-1:0] din_a_in,
   input wire logic [`MRAM_PORT_BE-1:0] be_a_in,
   output logic [`MRAM_PORT_DW-1:0] dout_a_out,
   // Port B
   input wire logic ce_b_in,
   input wire logic clr_b_in,
   input wire logic we_b_in,
   input wire logic [`MRAM_AW-1:0] addr_b_in,
   input wire logic [`MRAM_PORT_DW-1:0] din_b_in,
   input wire logic [`MRAM_PORT_BE-1:0] be_b_in,
   output logic [`MRAM_PORT_DW-1:0] dout_b_out,
   // Status
   output logic cfg_err_out,
   output logic fifo_full_out,
   output logic fifo_empty_out
);

   // ***************************************************************
   // Helper functions
   // ***************************************************************
   // Row index of a port address
   function automatic logic [`MRAM_ROW_AW-1:0] row_of(input logic [`MRAM_AW-1:0] a,
                                                     input logic [2:0] w);
      logic [`MRAM_AW-1:0] s;
      s = a >> (3'(`MRAM_MAX_SHIFT) - w);
      return s[`MRAM_ROW_AW-1:0];
   endfunction : row_of

   // First 9-bit lane of the word inside its row
   function automatic logic [3:0] lane_of(input logic [`MRAM_AW-1:0] a,
                                          input logic [2:0] w);
      logic [3:0] lo;
      lo = a[3:0] & ((4'h1 << (3'(`MRAM_MAX_SHIFT) - w)) - 4'h1);
      return 4'(lo << w);
   endfunction : lane_of

   // Spread 8-bit bytes into 9-bit lanes
   function automatic logic [`MRAM_ROW_BITS-1:0] pack8(input logic [`MRAM_ROW_BITS-1:0] d);
      logic [`MRAM_ROW_BITS-1:0] r;
      r = '0;
      for (int i = 0; i < `MRAM_LANES; i++) begin
         r[i*`MRAM_LANE_BITS +: `MRAM_LANE_BITS] = {1'b0, d[i*`MRAM_BYTE_BITS +: `MRAM_BYTE_BITS]};
      end
      return r;
   endfunction : pack8

   // Gather 9-bit lanes back into 8-bit bytes
   function automatic logic [`MRAM_ROW_BITS-1:0] unpack8(input logic [`MRAM_ROW_BITS-1:0] d);
      logic [`MRAM_ROW_BITS-1:0] r;
      r = '0;
      for (int i = 0; i < `MRAM_LANES; i++) begin
         r[i*`MRAM_BYTE_BITS +: `MRAM_BYTE_BITS] = d[i*`MRAM_LANE_BITS +: `MRAM_BYTE_BITS];
      end
      return r;
   endfunction : unpack8

   // Bit mask of the written lanes
   function automatic logic [`MRAM_ROW_BITS-1:0] bit_mask(input logic [`MRAM_LANES-1:0] be,
                                                          input logic [2:0] w,
                                                          input logic [3:0] lane);
      logic [`MRAM_LANES:0] width_m;
      logic [`MRAM_LANES-1:0] m;
      logic [`MRAM_ROW_BITS-1:0] r;
      width_m = (17'h0_0001 << w) ;
      width_m = (17'h0_0001 << width_m[4:0]) - 17'h0_0001;
      m = be & width_m[`MRAM_LANES-1:0];
      if (w == 3'(mram_pkg::width_x9)) begin
         m = 16'h0001;
      end
      m = m << lane;
      for (int i = 0; i < `MRAM_LANES; i++) begin
         r[i*`MRAM_LANE_BITS +: `MRAM_LANE_BITS] = {`MRAM_LANE_BITS{m[i]}};
      end
      return r;
   endfunction : bit_mask

   // Read slice of a row for one port
   function automatic logic [`MRAM_PORT_DW-1:0] rd_slice(input logic [`MRAM_ROW_BITS-1:0] row,
                                                        input logic [3:0] lane,
                                                        input logic [2:0] w,
                                                        input logic nar,
                                                        input logic upper);
      logic [`MRAM_ROW_BITS-1:0] s;
      s = row >> (lane * 8'(`MRAM_LANE_BITS));
      if (w == 3'(mram_pkg::width_x144) && upper) begin
         s = row >> `MRAM_PORT_DW;
      end
      if (nar) begin
         s = unpack8(s);
      end
      return s[`MRAM_PORT_DW-1:0];
   endfunction : rd_slice

   // ***************************************************************
   // Configuration check
   // ***************************************************************
   wire logic a_wide = (width_a_in == mram_pkg::width_x144);
   wire logic b_wide = (width_b_in == mram_pkg::width_x144);
   wire logic is_fifo = (mode_in == mram_pkg::mode_fifo);
   wire logic is_single = (mode_in == mram_pkg::mode_single);
   wire logic is_simple = (mode_in == mram_pkg::mode_simple_dual) || is_fifo;
   wire logic cfg_ok = (mode_in == mram_pkg::mode_true_dual) ? !a_wide && !b_wide
                     : is_simple ? (a_wide == b_wide)
                     && (!is_fifo || width_a_in == width_b_in)
                     : !a_wide;
   // Simple dual and FIFO write on A, read on B
   wire logic b_may_write = !is_simple && !is_single;

   // ***************************************************************
   // FIFO pointers
   // ***************************************************************
   logic [`MRAM_AW-1:0] wp_q, wp_d, rp_q, rp_d;
   logic [`MRAM_CNT_W-1:0] cnt_q, cnt_d;
   logic full_q, empty_q;
   wire logic [`MRAM_CNT_W-1:0] depth = `MRAM_CNT_W'(1) << (5'(`MRAM_AW) - 5'(width_a_in));
   wire logic push = is_fifo && ce_a_in && we_a_in && !full_q;
   wire logic pop = is_fifo && ce_b_in && !empty_q;
   assign wp_d = push ? wp_q + 16'h0001 : wp_q;
   assign rp_d = pop ? rp_q + 16'h0001 : rp_q;
   assign cnt_d = cnt_q + `MRAM_CNT_W'(push) - `MRAM_CNT_W'(pop);

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
         full_q <= 1'b0;
         empty_q <= 1'b1;
      end else begin
         wp_q <= is_fifo ? (wp_d & 16'(depth - 17'h0_0001)) : '0;
         rp_q <= is_fifo ? (rp_d & 16'(depth - 17'h0_0001)) : '0;
         cnt_q <= is_fifo ? cnt_d : '0;
         full_q <= is_fifo && (cnt_d == depth);
         empty_q <= !is_fifo || (cnt_d == '0);
      end
   end

   // ***************************************************************
   // Input registers
   // ***************************************************************
   logic we_a_q, we_b_q;
   logic [`MRAM_AW-1:0] addr_a_q, addr_b_q;
   logic [`MRAM_PORT_DW-1:0] din_a_q, din_b_q;
   logic [`MRAM_PORT_BE-1:0] be_a_q, be_b_q;
   wire logic we_a_d = cfg_ok && we_a_in && (!is_fifo || push);
   wire logic we_b_d = cfg_ok && we_b_in && b_may_write && !b_wide;
   wire logic [`MRAM_AW-1:0] addr_a_d = is_fifo ? wp_q : addr_a_in;
   wire logic [`MRAM_AW-1:0] addr_b_d = is_fifo ? rp_q : addr_b_in;

   // Single clock; per-port enable and clear stand for the port clocks
   always_ff @(posedge clk_in or negedge rst_b_in or posedge clr_a_in) begin
      if (!rst_b_in || clr_a_in) begin
         we_a_q <= 1'b0;
         addr_a_q <= '0;
         din_a_q <= '0;
         be_a_q <= '0;
      end else if (ce_a_in) begin
         we_a_q <= we_a_d;
         addr_a_q <= addr_a_d;
         din_a_q <= din_a_in;
         be_a_q <= be_a_in;
      end else begin
         we_a_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in or posedge clr_b_in) begin
      if (!rst_b_in || clr_b_in) begin
         we_b_q <= 1'b0;
         addr_b_q <= '0;
         din_b_q <= '0;
         be_b_q <= '0;
      end else if (ce_b_in) begin
         we_b_q <= we_b_d;
         addr_b_q <= addr_b_d;
         din_b_q <= din_b_in;
         be_b_q <= be_b_in;
      end else begin
         we_b_q <= 1'b0;
      end
   end

   // ***************************************************************
   // Array write
   // ***************************************************************
   logic [`MRAM_ROW_BITS-1:0] mem [`MRAM_ROWS];
   wire logic [`MRAM_ROW_AW-1:0] row_a = row_of(addr_a_q, width_a_in);
   wire logic [`MRAM_ROW_AW-1:0] row_b = row_of(addr_b_q, width_b_in);
   wire logic [3:0] lane_a = lane_of(addr_a_q, width_a_in);
   wire logic [3:0] lane_b = lane_of(addr_b_q, width_b_in);
   wire logic [`MRAM_LANES-1:0] be16_a = a_wide ? {be_b_q, be_a_q} : {8'h00, be_a_q};
   wire logic [`MRAM_LANES-1:0] be16_b = {8'h00, be_b_q};
   wire logic [`MRAM_ROW_BITS-1:0] raw_a = a_wide ? {din_b_q, din_a_q}
                                         : {`MRAM_PORT_DW'(0), din_a_q};
   wire logic [`MRAM_ROW_BITS-1:0] raw_b = {`MRAM_PORT_DW'(0), din_b_q};
   wire logic [`MRAM_ROW_BITS-1:0] wd_a = (narrow_a_in ? pack8(raw_a) : raw_a)
                                          << (lane_a * 8'(`MRAM_LANE_BITS));
   wire logic [`MRAM_ROW_BITS-1:0] wd_b = (narrow_b_in ? pack8(raw_b) : raw_b)
                                          << (lane_b * 8'(`MRAM_LANE_BITS));
   wire logic [`MRAM_ROW_BITS-1:0] wm_a = we_a_q ? bit_mask(be16_a, width_a_in, lane_a) : '0;
   wire logic [`MRAM_ROW_BITS-1:0] wm_b = we_b_q ? bit_mask(be16_b, width_b_in, lane_b) : '0;
   wire logic same_row = (row_a == row_b);
   // Both writers in one row merge; port B wins overlapping lanes
   wire logic [`MRAM_ROW_BITS-1:0] new_a = same_row
      ? (((mem[row_a] & ~wm_a) | (wd_a & wm_a)) & ~wm_b) | (wd_b & wm_b)
      : (mem[row_a] & ~wm_a) | (wd_a & wm_a);
   wire logic [`MRAM_ROW_BITS-1:0] new_b = (mem[row_b] & ~wm_b) | (wd_b & wm_b);

   always_ff @(posedge clk_in) begin
      if (we_a_q) begin
         mem[row_a] <= new_a;
      end
      if (we_b_q && !(we_a_q && same_row)) begin
         mem[row_b] <= new_b;
      end
   end

   // ***************************************************************
   // Read path
   // ***************************************************************
   // Read during write returns the old row contents
   wire logic [`MRAM_PORT_DW-1:0] rd_a = rd_slice(mem[row_a], lane_a, width_a_in,
                                                  narrow_a_in, 1'b0);
   wire logic [`MRAM_PORT_DW-1:0] rd_b = rd_slice(mem[row_b], lane_b, width_b_in,
                                                  narrow_b_in, 1'b1);
   logic [`MRAM_PORT_DW-1:0] stage_a_q, stage_b_q;

   always_ff @(posedge clk_in or negedge rst_b_in or posedge clr_a_in) begin
      if (!rst_b_in || clr_a_in) begin
         stage_a_q <= '0;
         dout_a_out <= '0;
      end else if (ce_a_in) begin
         stage_a_q <= rd_a;
         dout_a_out <= outreg_a_in ? stage_a_q : rd_a;
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in or posedge clr_b_in) begin
      if (!rst_b_in || clr_b_in) begin
         stage_b_q <= '0;
         dout_b_out <= '0;
      end else if (ce_b_in) begin
         stage_b_q <= rd_b;
         dout_b_out <= outreg_b_in ? stage_b_q : rd_b;
      end
   end

   // ***************************************************************
   // Status outputs
   // ***************************************************************
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cfg_err_out <= 1'b0;
         fifo_full_out <= 1'b0;
         fifo_empty_out <= 1'b1;
      end else begin
         cfg_err_out <= !cfg_ok;
         fifo_full_out <= full_q;
         fifo_empty_out <= empty_q;
      end
   end

endmodule : large_dual_port_block_ram
`default_nettype wire

// ---- verilog/mram_defs.svh ----
// Constants for the large dual-port block RAM.
// Assumes inclusion by bare name from files under verilog/.
`ifndef MRAM_DEFS_SVH
`define MRAM_DEFS_SVH

// ***************************************************************
// Array geometry
// ***************************************************************
`define MRAM_TOTAL_BITS 589824
`define MRAM_ROW_BITS 144
`define MRAM_ROWS 4096
`define MRAM_ROW_AW 12
`define MRAM_AW 16
`define MRAM_PORT_DW 72
`define MRAM_LANE_BITS 9
`define MRAM_BYTE_BITS 8
`define MRAM_LANES 16
`define MRAM_PORT_BE 8
`define MRAM_MAX_SHIFT 4
`define MRAM_CNT_W 17

`endif

// ---- verilog/mram_pkg.sv ----
// Types shared by the large dual-port block RAM.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package mram_pkg;
   // Operating mode
   typedef enum logic [1:0] {
      mode_true_dual,
      mode_simple_dual,
      mode_single,
      mode_fifo
   } mode_e;
   // Port organisation: code n means a 9 * 2**n bit word
   typedef enum logic [2:0] {
      width_x9,
      width_x18,
      width_x36,
      width_x72,
      width_x144
   } width_e;
endpackage : mram_pkg
`default_nettype wire

// ---- sim/mram_props.sv ----
// Concurrent checks on the block RAM's top-level ports.
// Assumes one clock domain and a bind from the bench top.
`timescale 1ns/1ps
`default_nettype none
`include "mram_defs.svh"
module mram_props (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // Configuration
   input wire mram_pkg::mode_e mode_in,
   input wire mram_pkg::width_e width_a_in,
   input wire mram_pkg::width_e width_b_in,
   // Port controls
   input wire logic ce_a_in,
   input wire logic ce_b_in,
   input wire logic clr_a_in,
   input wire logic clr_b_in,
   // Results
   input wire logic [`MRAM_PORT_DW-1:0] dout_a_out,
   input wire logic [`MRAM_PORT_DW-1:0] dout_b_out,
   input wire logic cfg_err_out,
   input wire logic fifo_full_out,
   input wire logic fifo_empty_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   // ******
   // Configuration and port checks
   // ******
   // Registered flag first follows the config one edge after release
   tdp_wide_a: assert property (
      rst_b_in && mode_in == mram_pkg::mode_true_dual
      && width_a_in == mram_pkg::width_x144 |=> cfg_err_out)
      else $error("wide true dual not flagged");
   tdp_legal_a: assert property (
      mode_in == mram_pkg::mode_true_dual && width_a_in != mram_pkg::width_x144
      && width_b_in != mram_pkg::width_x144 |=> !cfg_err_out) else $error("legal pair flagged");
   sdp_mixed_a: assert property (
      rst_b_in && mode_in == mram_pkg::mode_simple_dual
      && ((width_a_in == mram_pkg::width_x144)
      != (width_b_in == mram_pkg::width_x144)) |=> cfg_err_out) else $error("half wide not flagged");
   sdp_wide_a: assert property (
      mode_in == mram_pkg::mode_simple_dual && width_a_in == mram_pkg::width_x144
      && width_b_in == mram_pkg::width_x144 |=> !cfg_err_out) else $error("wide pair flagged");
   fifo_idle_a: assert property (
      mode_in != mram_pkg::mode_fifo |=> fifo_empty_out && !fifo_full_out)
      else $error("fifo flags outside fifo mode");
   clra_zero_a: assert property (clr_a_in |-> dout_a_out == '0)
      else $error("port a clear ignored");
   clrb_zero_a: assert property (clr_b_in |-> dout_b_out == '0)
      else $error("port b clear ignored");
   ce_hold_a: assert property (
      !ce_b_in && !clr_b_in ##1 !clr_b_in |-> $stable(dout_b_out))
      else $error("port b output moved without enable");
   dout_cause_a: assert property (
      $changed(dout_a_out) && !clr_a_in |-> $past(ce_a_in) || $past(clr_a_in))
      else $error("port a output moved without a clocked cause");
endmodule : mram_props
`default_nettype wire

// ---- sim/fabric_port.sv ----
// Fabric-side user logic driving one RAM port.
// Assumes the bench calls req and park; changes land just after an edge.
`timescale 1ns/1ps
`default_nettype none
`include "mram_defs.svh"
module fabric_port (
   // Clock
   input wire logic clk_in,
   // Port request
   output logic ce_out,
   output logic we_out,
   output logic [`MRAM_AW-1:0] addr_out,
   output logic [`MRAM_PORT_DW-1:0] din_out,
   output logic [`MRAM_PORT_BE-1:0] be_out
);
   initial begin
      ce_out = 1'b0;
      we_out = 1'b0;
      addr_out = '0;
      din_out = '0;
      be_out = '0;
   end
   task req(input logic w, input logic [15:0] a, input logic [71:0] d, input logic [7:0] b);
      @(posedge clk_in);
      ce_out <= 1'b1;
      we_out <= w;
      addr_out <= a;
      din_out <= d;
      be_out <= b;
      @(posedge clk_in);
      we_out <= 1'b0;
      din_out <= ~d;
      be_out <= ~b;
   endtask : req
   task park;
      @(posedge clk_in);
      ce_out <= 1'b0;
   endtask : park
endmodule : fabric_port
`default_nettype wire

// ---- sim/tb.sv ----
// Self-checking bench for the block RAM with a lane-level model.
// Assumes the design, package, defines and fabric_port are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk_in, rst_b_in, na, oa, ob, clr_a, clr_b, ce_a, we_a, ce_b, we_b, cfg_err, full, empty;
   mram_pkg::mode_e mode;
   mram_pkg::width_e wa, wb;
   logic [15:0] ad_a, ad_b;
   logic [71:0] di_a, di_b, do_a, do_b;
   logic [7:0] be_a, be_b;
   logic [143:0] d;
   logic [15:0] bev;
   logic [8:0] mem [int];
   integer fails = 0, comparisons = 0, seed = 33929, w, a;
   // ******
   // Clock, design and partners
   // ******
   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end
   large_dual_port_block_ram u_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .mode_in(mode),
      .width_a_in(wa), .width_b_in(wb), .narrow_a_in(na), .narrow_b_in(na), .outreg_a_in(oa),
      .outreg_b_in(ob), .ce_a_in(ce_a), .clr_a_in(clr_a), .we_a_in(we_a), .addr_a_in(ad_a),
      .din_a_in(di_a), .be_a_in(be_a), .dout_a_out(do_a), .ce_b_in(ce_b), .clr_b_in(clr_b),
      .we_b_in(we_b), .addr_b_in(ad_b), .din_b_in(di_b), .be_b_in(be_b), .dout_b_out(do_b),
      .cfg_err_out(cfg_err), .fifo_full_out(full), .fifo_empty_out(empty));
   fabric_port pa (.clk_in(clk_in), .ce_out(ce_a), .we_out(we_a), .addr_out(ad_a),
      .din_out(di_a), .be_out(be_a));
   fabric_port pb (.clk_in(clk_in), .ce_out(ce_b), .we_out(we_b), .addr_out(ad_b),
      .din_out(di_b), .be_out(be_b));
   // ******
   // Model and helpers
   // ******
   task check(input logic [143:0] seen, input logic [143:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   function automatic void mwr(int n, logic nar, int ad, logic [143:0] dd, logic [15:0] b);
      int base;
      base = (ad & ((1 << (16 - n)) - 1)) << n;
      for (int i = 0; i < (1 << n); i++)
         if (n == 0 || b[i]) mem[base + i] = nar ? {1'b0, dd[8*i +: 8]} : dd[9*i +: 9];
   endfunction : mwr
   task chk(input int n, input logic nar, input int ad, input logic [143:0] seen);
      logic [143:0] e, m;
      int base;
      e = '0;
      m = '0;
      base = (ad & ((1 << (16 - n)) - 1)) << n;
      for (int i = 0; i < (1 << n); i++) begin
         if (nar) begin
            e[8*i +: 8] = mem[base + i][7:0];
            m[8*i +: 8] = 8'hff;
         end else begin
            e[9*i +: 9] = mem[base + i];
            m[9*i +: 9] = 9'h1ff;
         end
      end
      check(seen & m, e);
   endtask : chk
   task reset_to(input mram_pkg::mode_e md, input int x, input int y, input logic nr);
      pa.park;
      pb.park;
      repeat (2) @(posedge clk_in);
      rst_b_in <= 1'b0;
      mode <= md;
      wa <= mram_pkg::width_e'(x);
      wb <= mram_pkg::width_e'(y);
      na <= nr;
      oa <= 1'($random(seed));
      ob <= 1'($random(seed));
      repeat (2) @(posedge clk_in);
      rst_b_in <= 1'b1;
      @(posedge clk_in);
      #1;
   endtask : reset_to
   task both(input logic wr, input int ad, input logic [143:0] dd, input logic [15:0] b);
      fork
         pa.req(wr, ad[15:0], dd[71:0], b[7:0]);
         pb.req(1'b0, ad[15:0], dd[143:72], b[15:8]);
      join
   endtask : both
   task settle;
      repeat (3) @(posedge clk_in);
      #1;
   endtask : settle
   task give_verdict;
      if (fails == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : give_verdict
   // ******
   // Scenarios
   // ******
   initial begin
      #(40 * 4000);
      fails++;
      give_verdict;
   end
   initial begin
      rst_b_in = 1'b0;
      {na, oa, ob, clr_a, clr_b} = '0;
      mode = mram_pkg::mode_true_dual;
      wa = mram_pkg::width_x72;
      wb = mram_pkg::width_x72;
      repeat (10) @(posedge clk_in);
      for (int n = 0; n < 4; n++) begin
         for (int k = 0; k < 2; k++) begin
            reset_to(mram_pkg::mode_true_dual, n, 3, k[0]);
            w = $random(seed) & 32'h0000_1fff;
            d = 144'({$random(seed), $random(seed), $random(seed)});
            pb.req(1'b1, w[15:0], d[71:0], 8'hff);
            mwr(3, k[0], w, d, 16'h00ff);
            a = (w << (3 - n)) + ($random(seed) & ((1 << (3 - n)) - 1));
            d = 144'({$random(seed), $random(seed), $random(seed)});
            bev = 16'($random(seed));
            pa.req(1'b1, a[15:0], d[71:0], bev[7:0]);
            mwr(n, k[0], a, d, {8'h00, bev[7:0]});
            pb.req(1'b0, w[15:0], '0, '0);
            settle;
            chk(3, k[0], w, {72'h0, do_b});
            pa.req(1'b0, a[15:0], '0, '0);
            settle;
            chk(n, k[0], a, {72'h0, do_a});
         end
      end
      @(posedge clk_in);
      clr_a <= 1'b1;
      clr_b <= 1'b1;
      settle;
      check({do_b, do_a}, '0);
      @(posedge clk_in);
      clr_a <= 1'b0;
      clr_b <= 1'b0;
      reset_to(mram_pkg::mode_true_dual, 4, 3, 1'b0);
      check(cfg_err, 1'b1);
      pa.req(1'b1, w[15:0], ~d[71:0], 8'hff);
      reset_to(mram_pkg::mode_true_dual, 3, 3, 1'b0);
      pb.req(1'b0, w[15:0], '0, '0);
      settle;
      chk(3, 1'b0, w, {72'h0, do_b});
      reset_to(mram_pkg::mode_simple_dual, 4, 3, 1'b0);
      check(cfg_err, 1'b1);
      reset_to(mram_pkg::mode_simple_dual, 4, 4, 1'b0);
      check(cfg_err, 1'b0);
      w = $random(seed) & 32'h0000_0fff;
      d = 144'({$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)});
      both(1'b1, w, d, 16'hffff);
      mwr(4, 1'b0, w, d, 16'hffff);
      d = 144'({$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)});
      bev = 16'($random(seed));
      both(1'b1, w, d, bev);
      mwr(4, 1'b0, w, d, bev);
      both(1'b0, w, '0, '0);
      settle;
      chk(4, 1'b0, w, {do_b, do_a});
      reset_to(mram_pkg::mode_single, 4, 3, 1'b0);
      check(cfg_err, 1'b1);
      reset_to(mram_pkg::mode_single, 3, 3, 1'b0);
      check(cfg_err, 1'b0);
      // Single port rewrites four lanes in the lower half of the row just filled
      a = 2 * w;
      pa.req(1'b1, a[15:0], d[71:0], 8'h5a);
      mwr(3, 1'b0, a, d, 16'h005a);
      pa.req(1'b0, a[15:0], '0, '0);
      settle;
      chk(3, 1'b0, a, {72'h0, do_a});
      reset_to(mram_pkg::mode_fifo, 3, 3, 1'b0);
      check({full, empty}, 2'b01);
      pa.req(1'b1, 16'h0000, d[71:0], 8'hff);
      settle;
      check(empty, 1'b0);
      give_verdict;
   end
endmodule : tb
bind large_dual_port_block_ram mram_props u_props (.clk_in(clk_in), .rst_b_in(rst_b_in),
   .mode_in(mode_in), .width_a_in(width_a_in), .width_b_in(width_b_in), .ce_a_in(ce_a_in),
   .ce_b_in(ce_b_in), .clr_a_in(clr_a_in), .clr_b_in(clr_b_in), .dout_a_out(dout_a_out),
   .dout_b_out(dout_b_out), .cfg_err_out(cfg_err_out), .fifo_full_out(fifo_full_out),
   .fifo_empty_out(fifo_empty_out));
`default_nettype wire
